// File: rtl/srf_pkg.sv
// Purpose: Constants and types for the shift, rotate and flag unit
// Assumes: 8-bit working register, 8-bit status flag register
// Notes:   Flag bit positions follow the usual I T H S V N Z C order
package srf_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned FLAG_W = 8;
   localparam int unsigned SEL_W  = 3;

   // ---------------------------------------------------------------
   // Status flag bit positions
   // ---------------------------------------------------------------
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;

   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET  = 8'h00;
   localparam int unsigned MSB        = 7;
   localparam int unsigned NIB        = 4;

   // ---------------------------------------------------------------
   // Operation codes, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      SRF_OP_NONE  = 7'h01,
      SRF_OP_ROL   = 7'h02,
      SRF_OP_ROR   = 7'h04,
      SRF_OP_ASR   = 7'h08,
      SRF_OP_SWAP  = 7'h10,
      SRF_OP_FSET  = 7'h20,
      SRF_OP_FCLR  = 7'h40
   } srf_op_t;

endpackage

// File: rtl/srf_flag_calc.sv
// Purpose: Z N V S flag values for a shift result
// Assumes: Carry out is already known
// Notes:   V is N xor C after any shift or rotate, S is N xor V
module srf_flag_calc (
   // Operand
   input  wire logic [7:0] result,
   input  wire logic       carry_out,
   // Flags
   output logic            zero,
   output logic            neg,
   output logic            ovf,
   output logic            sign
);
   always_comb begin
      zero = (result == srf_pkg::DATA_RESET);
      neg  = result[srf_pkg::MSB];
      ovf  = result[srf_pkg::MSB] ^ carry_out;
      sign = neg ^ ovf;
   end
endmodule

// File: rtl/srf_unit.sv
// Purpose: Single-cycle rotate, shift, swap and flag set/clear datapath
// Assumes: Decoder presents one op per cycle with a valid strobe
// Notes:   Holds working register and status flags; results in one cycle
module srf_unit (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   // Decoder request
   input  wire logic             op_valid,
   input  wire srf_pkg::srf_op_t op_code,
   input  wire logic [2:0]       flag_sel,
   // Working register load from register file
   input  wire logic             load_valid,
   input  wire logic [7:0]       load_data,
   // Results
   output logic [7:0]            work_reg,
   output logic [7:0]            status_flags_reg,
   output logic                  done
);

   // ---------------------------------------------------------------
   // Reset synchroniser
   // ---------------------------------------------------------------
   logic [1:0] rst_sync;
   logic       rst_n;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] flags;
      logic       done;
   } srf_state_t;

   srf_state_t st;
   srf_state_t next_st;

   logic [7:0] shift_res;
   logic       shift_c;
   logic       f_z;
   logic       f_n;
   logic       f_v;
   logic       f_s;

   // Shift result and carry out, shared by the three shift kinds
   always_comb begin
      shift_res = st.data;
      shift_c   = st.flags[srf_pkg::FLAG_C];
      case (op_code)
         srf_pkg::SRF_OP_ROL: begin
            shift_res = {st.data[6:0], st.flags[srf_pkg::FLAG_C]};
            shift_c   = st.data[srf_pkg::MSB];
         end
         srf_pkg::SRF_OP_ROR: begin
            shift_res = {st.flags[srf_pkg::FLAG_C], st.data[7:1]};
            shift_c   = st.data[0];
         end
         srf_pkg::SRF_OP_ASR: begin
            shift_res = {st.data[srf_pkg::MSB], st.data[7:1]};
            shift_c   = st.data[0];
         end
         default: begin
            shift_res = st.data;
            shift_c   = st.flags[srf_pkg::FLAG_C];
         end
      endcase
   end

   srf_flag_calc u_flags (
      .result    (shift_res),
      .carry_out (shift_c),
      .zero      (f_z),
      .neg       (f_n),
      .ovf       (f_v),
      .sign      (f_s)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      // A valid op wins over a register file load; the load applies only when no op is valid
      if (load_valid && !op_valid) begin
         next_st.data = load_data;
      end
      if (op_valid) begin
         next_st.done = 1'b1;
         case (op_code)
            srf_pkg::SRF_OP_ROL,
            srf_pkg::SRF_OP_ROR,
            srf_pkg::SRF_OP_ASR: begin
               next_st.data                     = shift_res;
               next_st.flags[srf_pkg::FLAG_C]   = shift_c;
               next_st.flags[srf_pkg::FLAG_Z]   = f_z;
               next_st.flags[srf_pkg::FLAG_N]   = f_n;
               next_st.flags[srf_pkg::FLAG_V]   = f_v;
               next_st.flags[srf_pkg::FLAG_S]   = f_s;
            end
            srf_pkg::SRF_OP_SWAP: begin
               // Flags deliberately left alone
               next_st.data = {st.data[srf_pkg::NIB-1:0],
                               st.data[srf_pkg::MSB:srf_pkg::NIB]};
            end
            srf_pkg::SRF_OP_FSET: begin
               next_st.flags[flag_sel] = 1'b1;
            end
            srf_pkg::SRF_OP_FCLR: begin
               next_st.flags[flag_sel] = 1'b0;
            end
            default: begin
               next_st.done = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{data: srf_pkg::DATA_RESET, flags: srf_pkg::FLAGS_RESET, done: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign work_reg         = st.data;
   assign status_flags_reg = st.flags;
   assign done             = st.done;

endmodule

// File: dv/srf_unit_properties.sv
// Purpose: Port checks for srf_unit
// Assumes: Flag bits 0..4 are C Z N V S
// Notes:   Results show one edge after the taking edge
module srf_unit_chk (
   input wire logic             core_clk,
   input wire logic             arst_n,
   input wire logic             op_valid,
   input wire srf_pkg::srf_op_t op_code,
   input wire logic [2:0]       flag_sel,
   input wire logic [7:0]       work_reg,
   input wire logic [7:0]       status_flags_reg,
   input wire logic             done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   rot_left_a:
   assert property (op_valid && op_code == srf_pkg::SRF_OP_ROL |=> done && status_flags_reg[0]
      == $past(work_reg[7]) && work_reg == {$past(work_reg[6:0]), $past(status_flags_reg[0])})
      else $error("rotate left wrong");
   rot_right_a:
   assert property (op_valid && op_code == srf_pkg::SRF_OP_ROR |=> done && status_flags_reg[0]
      == $past(work_reg[0]) && work_reg == {$past(status_flags_reg[0]), $past(work_reg[7:1])})
      else $error("rotate right wrong");
   shift_sign_a:
   assert property (op_valid && op_code == srf_pkg::SRF_OP_ASR |=> done && status_flags_reg[1]
      == (work_reg == 8'h00) && work_reg == {$past(work_reg[7]), $past(work_reg[7:1])})
      else $error("shift right wrong");
   swap_nibble_a:
   assert property (op_valid && op_code == srf_pkg::SRF_OP_SWAP |=> done && $stable(
      status_flags_reg) && work_reg == {$past(work_reg[3:0]), $past(work_reg[7:4])})
      else $error("swap wrong");
   flag_set_a:
   assert property (op_valid && op_code == srf_pkg::SRF_OP_FSET |=> done && status_flags_reg
      == ($past(status_flags_reg) | (8'h01 << $past(flag_sel)))) else $error("set wrong");
   flag_clear_a:
   assert property (op_valid && op_code == srf_pkg::SRF_OP_FCLR |=> done && status_flags_reg
      == ($past(status_flags_reg) & ~(8'h01 << $past(flag_sel)))) else $error("clear wrong");
endmodule
bind srf_unit srf_unit_chk chk (.core_clk, .arst_n, .op_valid, .op_code, .flag_sel,
   .work_reg, .status_flags_reg, .done);

// File: dv/srf_rf_model.sv
// Purpose: Register file side, takes each finished result
// Assumes: done marks a valid work_reg
// Notes:   Captured one edge later, like a write-back
module srf_rf_model (
   input  wire logic       core_clk,
   input  wire logic       done,
   input  wire logic [7:0] work_reg,
   output logic [7:0]      wb_data
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge core_clk) if (done) wb_data <= work_reg;
endmodule

// File: dv/tb_shift_rotate_flag_unit.sv
// Purpose: Directed bench for srf_unit
// Assumes: Flags reset to zero
// Notes:   Ops spaced one idle cycle apart
module tb_shift_rotate_flag_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic             core_clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, load_valid = 1'b0, done;
   srf_pkg::srf_op_t op_code = srf_pkg::SRF_OP_NONE;
   logic [2:0]       flag_sel = 3'h0;
   logic [7:0]       load_data = 8'h00, work_reg, status_flags_reg, wb_data, e;
   int               fails = 0, total_checks = 0;
   srf_unit dut (.core_clk, .arst_n, .op_valid, .op_code, .flag_sel, .load_valid, .load_data,
      .work_reg, .status_flags_reg, .done);
   srf_rf_model rf (.core_clk, .done, .work_reg, .wb_data);
   initial forever #5 core_clk = ~core_clk;
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic op(srf_pkg::srf_op_t c, logic [2:0] s, logic ld, logic [7:0] d);
      @(posedge core_clk);
      #1;
      op_valid = !ld;
      op_code = c;
      flag_sel = s;
      load_valid = ld;
      load_data = d;
      @(posedge core_clk);
      #1;
      op_valid = 1'b0;
      load_valid = 1'b0;
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      finish_test;
   end
   task automatic reset_test;
      chk(work_reg, 8'h00);
      chk(status_flags_reg, 8'h00);
      chk({7'h00, done}, 8'h00);
      $display("reset test done");
   endtask
   task automatic rotate_test;
      op(srf_pkg::SRF_OP_NONE, 3'h0, 1'b1, 8'h81);
      op(srf_pkg::SRF_OP_ROL, 3'h0, 1'b0, 8'h00);
      chk(work_reg, 8'h02);
      chk(status_flags_reg, 8'h19);
      chk({7'h00, done}, 8'h01);
      op(srf_pkg::SRF_OP_ROR, 3'h0, 1'b0, 8'h00);
      chk(work_reg, 8'h81);
      chk(status_flags_reg, 8'h0c);
      chk(wb_data, 8'h02);
      $display("rotate test done");
   endtask
   task automatic shift_test;
      op(srf_pkg::SRF_OP_NONE, 3'h0, 1'b1, 8'h01);
      op(srf_pkg::SRF_OP_ASR, 3'h0, 1'b0, 8'h00);
      chk(status_flags_reg, 8'h1b);
      op(srf_pkg::SRF_OP_NONE, 3'h0, 1'b1, 8'h80);
      op(srf_pkg::SRF_OP_ASR, 3'h0, 1'b0, 8'h00);
      chk(work_reg, 8'hc0);
      chk(status_flags_reg, 8'h0c);
      $display("shift test done");
   endtask
   task automatic swap_test;
      op(srf_pkg::SRF_OP_FSET, 3'h7, 1'b0, 8'ha5);
      op(srf_pkg::SRF_OP_NONE, 3'h0, 1'b1, 8'ha5);
      op(srf_pkg::SRF_OP_SWAP, 3'h0, 1'b0, 8'h00);
      chk(work_reg, 8'h5a);
      chk(status_flags_reg, 8'h8c);
      chk({7'h00, done}, 8'h01);
      $display("swap test done");
   endtask
   task automatic flag_test;
      e = 8'h8c;
      for (int i = 0; i < 8; i++) begin
         op(srf_pkg::SRF_OP_FSET, 3'(i), 1'b0, 8'h00);
         e |= 8'h01 << i;
         chk(status_flags_reg, e);
         op(srf_pkg::SRF_OP_FCLR, 3'(i), 1'b0, 8'h00);
         e &= ~(8'h01 << i);
         chk(status_flags_reg, e);
      end
      op(srf_pkg::SRF_OP_NONE, 3'h0, 1'b0, 8'h00);
      chk({7'h00, done}, 8'h00);
      $display("flag test done");
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      reset_test;
      rotate_test;
      shift_test;
      swap_test;
      flag_test;
      finish_test;
   end
endmodule
